// file: inc/sar_adc_map.vh
`ifndef SAR_ADC_MAP_VH
`define SAR_ADC_MAP_VH

// register byte offsets on the wishbone bus
`define ADC_OFS_MAIN 8'h00
`define ADC_OFS_CLKSEL 8'h04
`define ADC_OFS_CHAN 8'h08
`define ADC_OFS_MODE2 8'h0c
`define ADC_OFS_RES_BASE 8'h10
`define ADC_OFS_RESH_BASE 8'h20

// reset values
`define ADC_MAIN_RST 8'h00
`define ADC_CLKSEL_RST 8'h00
`define ADC_CHAN_RST 8'h00
`define ADC_MODE2_RST 8'h00

// main control field positions
`define ADC_CE_BIT 7
`define ADC_MD_HI_BIT 5
`define ADC_MD_LO_BIT 4
`define ADC_ETS_HI_BIT 3
`define ADC_ETS_LO_BIT 2
`define ADC_TMD_BIT 1
`define ADC_EF_BIT 0

// mode-2 field: trigger source in hardware mode (0 external, 1 timer)
`define ADC_M2_TSRC_BIT 0

// clock counts per conversion clock code (62, 93, 124)
`define ADC_CONV_01 8'h3e
`define ADC_CONV_10 8'h5d
`define ADC_CONV_11 8'h7c
// stabilization counts (33, 50, 54)
`define ADC_STAB_01 8'h21
`define ADC_STAB_10 8'h32
`define ADC_STAB_11 8'h36
// trigger acknowledge counts (6, 7, 8)
`define ADC_ACK_01 8'h06
`define ADC_ACK_10 8'h07
`define ADC_ACK_11 8'h08
// clocks spent on each approximation bit, and total bit clocks (10 x 4)
`define ADC_BIT_CLKS 8'h04
`define ADC_BITS_TOTAL 8'h28
// first trial value: top bit set
`define ADC_SAR_TOP 10'h200

`endif

// file: rtl/result_mem.v
`timescale 1ns/100ps
module result_mem #(
   parameter DW = 10,
   parameter AW = 2
) (
   input wire clk_i,
   input wire rst_i,
   input wire we_i,
   input wire [AW-1:0] wa_i,
   input wire [DW-1:0] wd_i,
   input wire [AW-1:0] ra_i,
   output reg [DW-1:0] rd_o
);
   localparam N = 1 << AW;
   reg [DW-1:0] mem_q [0:N-1];
   integer i;

   always @(posedge clk_i) begin
      if (rst_i) begin
         for (i = 0; i < N; i = i + 1) begin
            mem_q[i] <= {DW{1'b0}};
         end
         rd_o <= {DW{1'b0}};
      end else begin
         if (we_i) begin
            mem_q[wa_i] <= wd_i;
         end
         rd_o <= mem_q[ra_i];
      end
   end
endmodule

// file: rtl/trig_detect.v
`timescale 1ns/100ps
module trig_detect (
   input wire clk_i,
   input wire rst_i,
   input wire pin_i,
   input wire [1:0] edge_sel_i,
   output reg hit_o
);
   reg s1_q;
   reg s2_q;
   reg s3_q;
   wire rise = s2_q & ~s3_q;
   wire fall = ~s2_q & s3_q;

   ////////////////////////////////////////////////////////////////////////
   // two-flop sync, then edge select: 01 falling, 10 rising, 11 both
   always @(posedge clk_i) begin
      if (rst_i) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         hit_o <= 1'b0;
      end else begin
         s1_q <= pin_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
         hit_o <= (edge_sel_i[0] & fall) | (edge_sel_i[1] & rise);
      end
   end
endmodule

// file: rtl/sar_adc_sequencer.v
// Operation
// - ten-bit approximation, decided msb to lsb
// - top bit set when input at/above half
// - then bit 8 trial, tap from bit 9
// - keep trial bit if input at/above tap
// - lsb done: copy result to result register
// - interrupt after all conversions of the set
// - result word: upper ten bits, low six zero
// - byte view gives upper eight result bits
// - main control 8-bit, reset zero, bit0 read-only
// - mode field picks one of four modes
// - software trigger: enable write starts conversion
// - hardware trigger: enable write enters standby
// - enable bit cleared only by software
// - read-only flag shows conversion in progress
// - software mode: control write restarts sequence
// - hardware mode: control write returns to standby
// - conversion clock count includes sampling period
// - clock code selects 62, 93, 124 clocks
// - code also selects stabilize and acknowledge counts
// - channel register picks channel or scan end
`timescale 1ns/100ps
`include "sar_adc_map.vh"
module sar_adc_sequencer #(
   parameter RES_W = 10,
   parameter CH_W = 2
) (
   input wire clk_i,
   input wire rst_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   input wire cmp_i,
   input wire ext_trigger_in_i,
   input wire timer_trig_i,
   output reg conv_end_irq_o,
   output reg [RES_W-1:0] tap_o,
   output reg sample_o,
   output reg [CH_W-1:0] chan_o
);
   localparam [5:0] S_IDLE = 6'b000001;
   localparam [5:0] S_STAB = 6'b000010;
   localparam [5:0] S_STBY = 6'b000100;
   localparam [5:0] S_ACK = 6'b001000;
   localparam [5:0] S_CONV = 6'b010000;
   localparam [5:0] S_DONE = 6'b100000;
   localparam [7:0] MAIN_RST = `ADC_MAIN_RST;
   localparam [7:0] CLK_RST = `ADC_CLKSEL_RST;
   localparam [7:0] CHAN_RST = `ADC_CHAN_RST;

   ////////////////////////////////////////////////////////////////////////
   // clock count lookup: kind 0 conversion, 1 stabilize, 2 acknowledge
   function [7:0] clk_count;
      input [1:0] kind;
      input [1:0] code;
      begin
         case (kind)
            2'd1: begin
               clk_count = (code == 2'b11) ? `ADC_STAB_11 :
                  (code == 2'b10) ? `ADC_STAB_10 : `ADC_STAB_01;
            end
            2'd2: begin
               clk_count = (code == 2'b11) ? `ADC_ACK_11 :
                  (code == 2'b10) ? `ADC_ACK_10 : `ADC_ACK_01;
            end
            default: begin
               clk_count = (code == 2'b11) ? `ADC_CONV_11 :
                  (code == 2'b10) ? `ADC_CONV_10 : `ADC_CONV_01;
            end
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // registers
   reg ce_q;
   reg [1:0] md_q;
   reg [1:0] ets_q;
   reg tmd_q;
   reg [1:0] fr_q;
   reg [7:0] mode2_q;
   reg [CH_W-1:0] chs_q;
   reg [5:0] st_q;
   reg [7:0] cnt_q;
   reg first_q;
   reg trig_pend_q;
   reg [RES_W-1:0] sar_q;
   reg [CH_W-1:0] ch_q;
   reg mem_we_q;
   reg [CH_W-1:0] mem_wa_q;
   reg [RES_W-1:0] mem_wd_q;
   reg pend_q;
   reg cmp_s1_q;
   reg cmp_s2_q;
   reg [31:0] rd_d;

   wire [RES_W-1:0] mem_rd;
   wire ext_hit;

   ////////////////////////////////////////////////////////////////////////
   // derived timing for the selected clock code
   wire [7:0] conv_len = clk_count(2'd0, fr_q);
   wire [7:0] stab_len = clk_count(2'd1, fr_q);
   wire [7:0] ack_len = clk_count(2'd2, fr_q);
   wire [7:0] samp_len = conv_len - `ADC_BITS_TOTAL;
   wire [7:0] step = cnt_q - samp_len;
   wire [3:0] bit_idx = 4'd9 - {1'b0, step[4:2]} - {3'b000, step[5]} * 4'd8;
   wire in_bits = (cnt_q >= samp_len);
   wire decide = in_bits & (step[1:0] == 2'b11);
   wire scan = md_q[0];
   wire one_shot = md_q[1];
   wire active = (st_q == S_STAB) | (st_q == S_ACK) | (st_q == S_CONV);
   wire busy = (st_q == S_ACK) | (st_q == S_CONV) | (st_q == S_DONE);
   wire [CH_W-1:0] first_ch = scan ? {CH_W{1'b0}} : chs_q;
   wire hw_hit = mode2_q[`ADC_M2_TSRC_BIT] ? timer_trig_i : ext_hit;

   ////////////////////////////////////////////////////////////////////////
   // wishbone slave: answer two edges after the request is presented
   wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire wr = req & pend_q & wb_we_i & wb_sel_i[0];
   wire wr_main = wr & (wb_adr_i == `ADC_OFS_MAIN);
   wire wr_clk = wr & (wb_adr_i == `ADC_OFS_CLKSEL);
   wire wr_chan = wr & (wb_adr_i == `ADC_OFS_CHAN);
   wire wr_m2 = wr & (wb_adr_i == `ADC_OFS_MODE2);
   wire wr_abort = wr_main | wr_chan | wr_m2;
   wire ce_new = wb_dat_i[`ADC_CE_BIT];

   always @* begin
      rd_d = 32'h0000_0000;
      if (wb_adr_i == `ADC_OFS_MAIN) begin
         rd_d[7:0] = {ce_q, 1'b0, md_q, ets_q, tmd_q, active};
      end else if (wb_adr_i == `ADC_OFS_CLKSEL) begin
         rd_d[1:0] = fr_q;
      end else if (wb_adr_i == `ADC_OFS_CHAN) begin
         rd_d[CH_W-1:0] = chs_q;
      end else if (wb_adr_i == `ADC_OFS_MODE2) begin
         rd_d[7:0] = mode2_q;
      end else if (wb_adr_i[7:4] == `ADC_OFS_RES_BASE >> 4 && wb_adr_i[1:0] == 2'b00) begin
         rd_d[15:0] = {mem_rd, 6'h00};
      end else if (wb_adr_i[7:4] == `ADC_OFS_RESH_BASE >> 4 && wb_adr_i[1:0] == 2'b00) begin
         rd_d[7:0] = mem_rd[RES_W-1:RES_W-8];
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         pend_q <= 1'b0;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         pend_q <= req & ~pend_q;
         wb_ack_o <= req & pend_q;
         if (req & pend_q) begin
            wb_dat_o <= wb_we_i ? 32'h0000_0000 : rd_d;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // configuration registers
   always @(posedge clk_i) begin
      if (rst_i) begin
         ce_q <= MAIN_RST[`ADC_CE_BIT];
         md_q <= MAIN_RST[`ADC_MD_HI_BIT:`ADC_MD_LO_BIT];
         ets_q <= MAIN_RST[`ADC_ETS_HI_BIT:`ADC_ETS_LO_BIT];
         tmd_q <= MAIN_RST[`ADC_TMD_BIT];
         fr_q <= CLK_RST[1:0];
         mode2_q <= `ADC_MODE2_RST;
         chs_q <= CHAN_RST[CH_W-1:0];
      end else begin
         if (wr_main) begin
            ce_q <= ce_new;
            md_q <= wb_dat_i[`ADC_MD_HI_BIT:`ADC_MD_LO_BIT];
            ets_q <= wb_dat_i[`ADC_ETS_HI_BIT:`ADC_ETS_LO_BIT];
            tmd_q <= wb_dat_i[`ADC_TMD_BIT];
         end
         if (wr_clk) begin
            fr_q <= wb_dat_i[1:0];
         end
         if (wr_m2) begin
            mode2_q <= wb_dat_i[7:0];
         end
         if (wr_chan) begin
            chs_q <= wb_dat_i[CH_W-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // comparator synchroniser
   always @(posedge clk_i) begin
      if (rst_i) begin
         cmp_s1_q <= 1'b0;
         cmp_s2_q <= 1'b0;
      end else begin
         cmp_s1_q <= cmp_i;
         cmp_s2_q <= cmp_s1_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // conversion sequencer
   always @(posedge clk_i) begin
      if (rst_i) begin
         st_q <= S_IDLE;
         cnt_q <= 8'h00;
         first_q <= 1'b0;
         trig_pend_q <= 1'b0;
         sar_q <= {RES_W{1'b0}};
         ch_q <= {CH_W{1'b0}};
         mem_we_q <= 1'b0;
         mem_wa_q <= {CH_W{1'b0}};
         mem_wd_q <= {RES_W{1'b0}};
         conv_end_irq_o <= 1'b0;
      end else begin
         conv_end_irq_o <= 1'b0;
         mem_we_q <= 1'b0;
         if (wr_main & ~ce_new) begin
            st_q <= S_IDLE;
            trig_pend_q <= 1'b0;
         end else if (wr_main & ce_new & ~ce_q) begin
            st_q <= S_STAB;
            cnt_q <= 8'h00;
            first_q <= 1'b1;
            trig_pend_q <= 1'b0;
         end else if (wr_abort & busy) begin
            if (tmd_q) begin
               st_q <= S_STBY;
            end else begin
               // one acknowledge clock lets the new settings land first
               st_q <= S_ACK;
               cnt_q <= ack_len - 8'h01;
            end
         end else begin
            case (st_q)
               S_STAB: begin
                  cnt_q <= cnt_q + 8'h01;
                  if (hw_hit) begin
                     trig_pend_q <= 1'b1;
                  end
                  if (cnt_q == stab_len - 8'h01) begin
                     cnt_q <= 8'h00;
                     trig_pend_q <= 1'b0;
                     if (~tmd_q | trig_pend_q | hw_hit) begin
                        st_q <= S_ACK;
                     end else begin
                        st_q <= S_STBY;
                     end
                  end
               end
               S_STBY: begin
                  if (hw_hit) begin
                     cnt_q <= 8'h00;
                     if (first_q) begin
                        st_q <= S_ACK;
                     end else begin
                        st_q <= S_CONV;
                        ch_q <= first_ch;
                     end
                  end
               end
               S_ACK: begin
                  cnt_q <= cnt_q + 8'h01;
                  if (cnt_q >= ack_len - 8'h01) begin
                     first_q <= 1'b0;
                     cnt_q <= 8'h00;
                     st_q <= S_CONV;
                     ch_q <= first_ch;
                  end
               end
               S_CONV: begin
                  cnt_q <= cnt_q + 8'h01;
                  if (cnt_q == samp_len - 8'h01) begin
                     sar_q <= `ADC_SAR_TOP;
                  end
                  if (decide) begin
                     sar_q[bit_idx] <= cmp_s2_q;
                     if (bit_idx != 4'd0) begin
                        sar_q[bit_idx - 4'd1] <= 1'b1;
                     end
                  end
                  if (cnt_q == conv_len - 8'h01) begin
                     mem_we_q <= 1'b1;
                     mem_wa_q <= ch_q;
                     mem_wd_q <= {sar_q[RES_W-1:1], cmp_s2_q};
                     cnt_q <= 8'h00;
                     if (scan & (ch_q != chs_q)) begin
                        ch_q <= ch_q + {{(CH_W-1){1'b0}}, 1'b1};
                     end else begin
                        conv_end_irq_o <= 1'b1;
                        if (tmd_q) begin
                           st_q <= S_STBY;
                        end else if (one_shot) begin
                           st_q <= S_DONE;
                        end else begin
                           ch_q <= first_ch;
                        end
                     end
                  end
               end
               S_DONE: begin
                  st_q <= S_DONE;
               end
               default: begin
                  st_q <= ce_q ? S_STAB : S_IDLE;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // analog-side outputs
   always @(posedge clk_i) begin
      if (rst_i) begin
         tap_o <= {RES_W{1'b0}};
         sample_o <= 1'b0;
         chan_o <= {CH_W{1'b0}};
      end else begin
         tap_o <= sar_q;
         sample_o <= (st_q == S_CONV) & ~in_bits;
         chan_o <= ch_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // submodules
   trig_detect u_trig (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pin_i(ext_trigger_in_i),
      .edge_sel_i(ets_q),
      .hit_o(ext_hit)
   );

   result_mem #(
      .DW(RES_W),
      .AW(CH_W)
   ) u_mem (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .we_i(mem_we_q),
      .wa_i(mem_wa_q),
      .wd_i(mem_wd_q),
      .ra_i(wb_adr_i[3:2]),
      .rd_o(mem_rd)
   );
endmodule

// file: verif/adc_seq_properties.sv
`timescale 1ns/100ps
module adc_seq_properties #(
   parameter RES_W = 10
) (
   input wire clk_i,
   input wire rst_i,
   input wire wb_cyc_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [31:0] wb_dat_o,
   input wire wb_ack_o,
   input wire conv_end_irq_o,
   input wire [RES_W-1:0] tap_o,
   input wire sample_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   reg [7:0] hi_q;
   reg [7:0] since_q;
   reg smp_q;
   reg ab_q;
   wire rd_w = wb_ack_o & ~wb_we_i;
   function [RES_W-1:0] low1(input [RES_W-1:0] v);
      low1 = v & (~v + 1'b1);
   endfunction
   ////////////////////////////////////////////////////////////////////////////////
   // sampling length, bus writes during sampling, clocks since sampling ended
   always @(posedge clk_i) begin
      if (rst_i) begin
         hi_q <= 8'h00;
         since_q <= 8'hff;
         smp_q <= 1'b0;
         ab_q <= 1'b0;
      end else begin
         smp_q <= sample_o;
         hi_q <= sample_o ? hi_q + 8'h01 : 8'h00;
         ab_q <= sample_o & (ab_q | (wb_cyc_i & wb_we_i));
         if (smp_q & ~sample_o)
            since_q <= 8'h00;
         else if (since_q != 8'hff)
            since_q <= since_q + 8'h01;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   property p_irq_pulse;
      conv_end_irq_o |=> !conv_end_irq_o;
   endproperty
   a_irq_pulse: assert property (p_irq_pulse) else $error("irq wider than one clock");
   property p_sample_len;
      (smp_q && !sample_o && !ab_q) |-> (hi_q == 8'h16 || hi_q == 8'h35 || hi_q == 8'h54);
   endproperty
   a_sample_len: assert property (p_sample_len) else $error("bad sampling length");
   property p_irq_win;
      conv_end_irq_o |-> (since_q >= 8'h26 && since_q <= 8'h2b);
   endproperty
   a_irq_win: assert property (p_irq_win) else $error("irq not after ten bit steps");
   property p_first;
      ($past(tap_o) == 10'h200 && tap_o != 10'h200 && tap_o != 10'h000)
         |-> (tap_o == 10'h100 || tap_o == 10'h300);
   endproperty
   a_first: assert property (p_first) else $error("bad second trial tap");
   property p_walk;
      (tap_o != $past(tap_o) && tap_o != 10'h000 && $past(tap_o) != 10'h000
         && tap_o != 10'h200 && low1($past(tap_o)) > 10'h001)
         |-> (low1(tap_o) == (low1($past(tap_o)) >> 1)
         && {1'b0, tap_o ^ $past(tap_o)} < {low1($past(tap_o)), 1'b0});
   endproperty
   a_walk: assert property (p_walk) else $error("trial bit out of order");
   property p_busy;
      (rd_w && wb_adr_i == 8'h00 && $past(sample_o)) |-> wb_dat_o[0];
   endproperty
   a_busy: assert property (p_busy) else $error("active flag low while sampling");
   property p_res_fmt;
      (rd_w && wb_adr_i[7:4] == 4'h1) |-> (wb_dat_o[5:0] == 6'h00 && wb_dat_o[31:16] == 16'h0000);
   endproperty
   a_res_fmt: assert property (p_res_fmt) else $error("result word format");
   property p_byte_fmt;
      (rd_w && wb_adr_i[7:4] == 4'h2) |-> wb_dat_o[31:8] == 24'h00_0000;
   endproperty
   a_byte_fmt: assert property (p_byte_fmt) else $error("result byte format");
   property p_main_fmt;
      (rd_w && wb_adr_i == 8'h00) |-> (wb_dat_o[31:8] == 24'h00_0000 && !wb_dat_o[6]);
   endproperty
   a_main_fmt: assert property (p_main_fmt) else $error("main control format");
endmodule

bind sar_adc_sequencer adc_seq_properties #(.RES_W(RES_W)) u_props (
   .clk_i(clk_i),
   .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i),
   .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i),
   .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o),
   .conv_end_irq_o(conv_end_irq_o),
   .tap_o(tap_o),
   .sample_o(sample_o)
);

// file: verif/adc_front_model.sv
`timescale 1ns/100ps
module adc_front_model (
   input wire [9:0] tap_i,
   input wire [1:0] chan_i,
   input wire [39:0] vin_i,
   output wire cmp_o
);
   // held input of the selected channel against the current tap
   assign cmp_o = vin_i[chan_i * 10 +: 10] >= tap_i;
endmodule

// file: verif/testbench.sv
`timescale 1ns/100ps
`include "sar_adc_map.vh"
module testbench;
   reg clk_i;
   reg rst_i;
   reg cyc;
   reg we;
   reg [7:0] adr;
   reg [31:0] wdat;
   reg tmr;
   reg ext;
   reg [39:0] vin;
   reg [15:0] lf;
   reg [31:0] rdat;
   wire [31:0] dat_o;
   wire ack;
   wire cmp;
   wire irq;
   wire [9:0] tap;
   wire smp;
   wire [1:0] ch;
   integer err_total;
   integer samples_checked;
   integer i;
   integer c;
   integer n;
   integer exp_r[$];
   sar_adc_sequencer dut (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wb_cyc_i(cyc),
      .wb_stb_i(cyc),
      .wb_we_i(we),
      .wb_adr_i(adr),
      .wb_sel_i(4'hf),
      .wb_dat_i(wdat),
      .wb_dat_o(dat_o),
      .wb_ack_o(ack),
      .cmp_i(cmp),
      .ext_trigger_in_i(ext),
      .timer_trig_i(tmr),
      .conv_end_irq_o(irq),
      .tap_o(tap),
      .sample_o(smp),
      .chan_o(ch)
   );
   adc_front_model u_front (
      .tap_i(tap),
      .chan_i(ch),
      .vin_i(vin),
      .cmp_o(cmp)
   );
   ////////////////////////////////////////////////////////////////////////////////
   function [15:0] lfsr(input [15:0] s);
      lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // reference approximation: trial each bit from the top, keep it if input >= tap
   function integer sar_ref(input integer v);
      integer b;
      begin
         sar_ref = 0;
         for (b = 9; b >= 0; b = b - 1) begin
            if (v >= sar_ref + (1 << b))
               sar_ref = sar_ref + (1 << b);
         end
      end
   endfunction
   task chk(input [31:0] got, input [31:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (got !== exp) begin
            err_total = err_total + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task stop_test;
      begin
         if (err_total == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   task bus(input w, input [7:0] a, input [7:0] d);
      integer k;
      begin
         cyc <= 1'b1;
         we <= w;
         adr <= a;
         wdat <= {24'h00_0000, d};
         k = 0;
         @(posedge clk_i);
         while (ack !== 1'b1 && k < 20) begin
            @(posedge clk_i);
            k = k + 1;
         end
         rdat = dat_o;
         cyc <= 1'b0;
         @(posedge clk_i);
         if (k == 20) begin
            err_total = err_total + 1;
            stop_test;
         end
      end
   endtask
   task rd(input [7:0] a);
      bus(1'b0, a, 8'h00);
   endtask
   task wr(input [7:0] a, input [7:0] d);
      bus(1'b1, a, d);
   endtask
   task wirq;
      begin
         n = 1;
         @(posedge clk_i);
         while (irq !== 1'b1 && n < 3000) begin
            @(posedge clk_i);
            n = n + 1;
         end
         if (n == 3000) begin
            err_total = err_total + 1;
            stop_test;
         end
      end
   endtask
   task quiet(input integer m);
      integer k;
      begin
         k = 0;
         repeat (m) begin
            @(posedge clk_i);
            if (irq !== 1'b0)
               k = k + 1;
         end
         chk(k, 0);
      end
   endtask
   task setv;
      begin
         exp_r.delete();
         for (i = 0; i < 4; i = i + 1) begin
            lf = lfsr(lf);
            vin[i*10 +: 10] <= lf[9:0];
            exp_r.push_back(sar_ref(lf[9:0]));
         end
      end
   endtask
   task res(input [1:0] k);
      begin
         rd(`ADC_OFS_RES_BASE | {4'h0, k, 2'h0});
         chk(rdat, exp_r[k] << 6);
         rd(`ADC_OFS_RESH_BASE | {4'h0, k, 2'h0});
         chk(rdat, exp_r[k] >> 2);
      end
   endtask
   task pulse;
      begin
         tmr <= 1'b1;
         @(posedge clk_i);
         tmr <= 1'b0;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   initial begin
      err_total = 0;
      samples_checked = 0;
      lf = 16'h0039;
      rst_i = 1'b1;
      cyc = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      wdat = 32'h0000_0000;
      tmr = 1'b0;
      ext = 1'b0;
      vin = 40'h00_0000_0000;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      for (c = 0; c < 68; c = c + 4) begin
         rd(c[7:0]);
         chk(rdat, 32'h0000_0000);
      end
      wr(`ADC_OFS_MAIN, 8'h01);
      rd(`ADC_OFS_MAIN);
      chk(rdat, 32'h0000_0000);
      for (c = 1; c < 4; c = c + 1) begin
         setv;
         wr(`ADC_OFS_CLKSEL, c[7:0]);
         wr(`ADC_OFS_CHAN, c[7:0]);
         wr(`ADC_OFS_MAIN, 8'ha0);
         rd(`ADC_OFS_MAIN);
         chk(rdat, 32'h0000_00a1);
         wirq;
         // bus overhead: six edges between the enable landing and the first wait edge, less one as irq is seen an edge late
         chk(n + 5, (c == 1) ? 33 + 6 + 62 : (c == 2) ? 50 + 7 + 93 : 54 + 8 + 124);
         res(c[1:0]);
         rd(`ADC_OFS_MAIN);
         chk(rdat, 32'h0000_00a0);
         quiet(300);
         wr(`ADC_OFS_MAIN, 8'h80);
         wirq;
         wirq;
         chk(n, 31 * c + 31);
         rd(`ADC_OFS_MAIN);
         chk(rdat, 32'h0000_0081);
         wr(`ADC_OFS_MAIN, 8'h00);
         quiet(300);
      end
      wr(`ADC_OFS_CLKSEL, 8'h01);
      wr(`ADC_OFS_CHAN, 8'h03);
      for (c = 0; c < 2; c = c + 1) begin
         setv;
         wr(`ADC_OFS_MAIN, (c == 1) ? 8'hb0 : 8'h90);
         wirq;
         for (i = 0; i < 4; i = i + 1)
            res(i[1:0]);
         wr(`ADC_OFS_MAIN, 8'h00);
      end
      setv;
      wr(`ADC_OFS_CHAN, 8'h01);
      wr(`ADC_OFS_MAIN, 8'ha0);
      repeat (80) @(posedge clk_i);
      wr(`ADC_OFS_CHAN, 8'h02);
      wirq;
      res(2'h2);
      wr(`ADC_OFS_MAIN, 8'h00);
      wr(`ADC_OFS_MODE2, 8'h01);
      wr(`ADC_OFS_CHAN, 8'h01);
      setv;
      wr(`ADC_OFS_MAIN, 8'ha2);
      quiet(200);
      rd(`ADC_OFS_MAIN);
      chk(rdat, 32'h0000_00a2);
      pulse;
      repeat (50) @(posedge clk_i);
      wr(`ADC_OFS_CHAN, 8'h01);
      quiet(200);
      pulse;
      wirq;
      res(2'h1);
      wr(`ADC_OFS_MAIN, 8'h00);
      wr(`ADC_OFS_MODE2, 8'h00);
      setv;
      wr(`ADC_OFS_MAIN, 8'haa);
      repeat (60) @(posedge clk_i);
      ext <= 1'b1;
      wirq;
      res(2'h1);
      // falling edge, then both edges, on the external trigger pin
      for (c = 0; c < 2; c = c + 1) begin
         wr(`ADC_OFS_MAIN, 8'h00);
         setv;
         wr(`ADC_OFS_MAIN, (c == 0) ? 8'ha6 : 8'hae);
         repeat (60) @(posedge clk_i);
         ext <= ~ext;
         wirq;
         res(2'h1);
      end
      stop_test;
   end
endmodule
